// ==== rtl/ast_pkg.sv ====
// Shared constants and types for the asynchronous serial transceiver.
// Assumes a single system clock; all offsets are byte addresses on AXI4-Lite.
`default_nettype none

package ast_pkg;

    // Register map
    localparam int               ADDR_W      = 5;
    localparam logic [ADDR_W-1:0] OFS_FORMAT  = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_TXDATA  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_RXDATA  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_BAUD    = 5'h14;

    // Reset values and write masks
    localparam logic [7:0]  FORMAT_RST  = 8'h00;
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [7:0]  FORMAT_MASK = 8'h1F;
    localparam logic [7:0]  CONTROL_MASK = 8'hF7;
    localparam logic [15:0] BAUD_RST    = 16'h0040;

    // Status bit positions
    localparam int ST_TX_BUF_EMPTY   = 7;
    localparam int ST_RX_BUF_FULL   = 6;
    localparam int ST_OVR    = 5;
    localparam int ST_FRM    = 4;
    localparam int ST_PAR    = 3;
    localparam int ST_TX_END_FLAG   = 2;
    localparam int ST_MPB_RX = 1;
    localparam int ST_MPB_TX = 0;

    // Bus answers
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // Sixteen ticks per bit: sample at the eighth, bit ends on the last
    localparam logic [3:0] PH_SAMPLE = 4'h7;
    localparam logic [3:0] PH_LAST   = 4'hF;

    // Clock select codes
    localparam logic [1:0] CKS_GPIO = 2'h0;
    localparam logic [1:0] CKS_OUT  = 2'h1;
    localparam logic [1:0] CKS_EXT  = 2'h2;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       char7;
        logic       pen;
        logic       podd;
        logic       mp;
        logic       stop2;
    } ast_format_t;

    typedef struct packed {
        logic       tx_irq_enable;
        logic       rx_irq_enable;
        logic       te;
        logic       re;
        logic       rsvd;
        logic       tx_end_irq_enable;
        logic [1:0] cks;
    } ast_control_t;

    typedef enum logic [0:0] {AST_TX_IDLE, AST_TX_RUN} ast_tx_state_t;
    typedef enum logic [1:0] {AST_RX_IDLE, AST_RX_START, AST_RX_BITS} ast_rx_state_t;

endpackage

`default_nettype wire

// ==== rtl/ast_serial_unit.sv ====
// Asynchronous serial transceiver with AXI4-Lite register access.
// Assumes synchronous pin inputs and one system clock.
//
// Contract
// R1: Frame is low start, data LSB first, optional parity, high stop; idle high.
// R2: Receiver syncs on start falling edge, samples on eighth of sixteen ticks.
// R3: Format bits pick 7/8 data, parity, multiprocessor bit, one or two stops.
// R4: Clock select bits choose internal baud generator or external pin clock.
// R5: Select 00 pin unused, 01 bit clock out, 10 external input, 11 reserved.
// R6: External clock source runs at sixteen times the bit rate.
// R7: Output clock runs at bit rate, rising edge at each bit centre.
// R8: Software clears both enables before changing mode or format.
// R9: Clearing transmit enable forces transmit buffer empty flag to one.
// R10: Clearing receive enable keeps receive flags and receive buffer unchanged.
// R11: External clock keeps running continuously, also during initialisation.
// R12: Buffer-empty flag low moves buffer to shifter, sets flag, starts sending.
// R13: At stop bit, a full buffer loads the next frame back to back.
// R14: An empty buffer at stop bit sets transmit end and holds line high.
// R15: Receiver shifts data LSB first, then parity and stop bits.
// R16: Parity checked against odd/even select; only first stop bit checked.
// R17: Error-free character goes to receive buffer and sets receive full.
// R18: Error sets its flag, leaves receive full, requests error interrupt.
// R19: Character completing while receive full flags overrun, buffer kept.
// R20: Zero stop bit flags framing error, character still stored.
// R21: Parity mismatch flags parity error, character not stored.
// R22: Reception waits while any error flag is set until software clears.
// R23: Transmitter generates parity over data per odd/even select.
`default_nettype none

module ast_serial_unit (
    input  wire logic                     CLK_SYS_IN,
    input  wire logic                     RST_N_IN,
    input  wire logic [ast_pkg::ADDR_W-1:0] AXI_AWADDR_IN,
    input  wire logic                     AXI_AWVALID_IN,
    output logic                          AXI_AWREADY_OUT,
    input  wire logic [31:0]              AXI_WDATA_IN,
    input  wire logic [3:0]               AXI_WSTRB_IN,
    input  wire logic                     AXI_WVALID_IN,
    output logic                          AXI_WREADY_OUT,
    output logic [1:0]                    AXI_BRESP_OUT,
    output logic                          AXI_BVALID_OUT,
    input  wire logic                     AXI_BREADY_IN,
    input  wire logic [ast_pkg::ADDR_W-1:0] AXI_ARADDR_IN,
    input  wire logic                     AXI_ARVALID_IN,
    output logic                          AXI_ARREADY_OUT,
    output logic [31:0]                   AXI_RDATA_OUT,
    output logic [1:0]                    AXI_RRESP_OUT,
    output logic                          AXI_RVALID_OUT,
    input  wire logic                     AXI_RREADY_IN,
    output logic                          TXD_OUT,
    input  wire logic                     RXD_IN,
    input  wire logic                     SERIAL_CLK_IN,
    output logic                          SERIAL_CLK_OUT,
    output logic                          SERIAL_CLK_OE_OUT,
    output logic                          TX_EMPTY_IRQ_OUT,
    output logic                          TX_END_IRQ_OUT,
    output logic                          RX_FULL_IRQ_OUT,
    output logic                          RX_ERROR_IRQ_OUT
);

    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Parity of the active data bits
    function automatic logic data_xor(input logic [7:0] d, input logic c7);
        return c7 ? ^d[6:0] : ^d;
    endfunction

    // Offsets answered with OKAY; anything else gets SLVERR
    function automatic logic is_mapped(input logic [ast_pkg::ADDR_W-1:0] a);
        return a == ast_pkg::OFS_FORMAT || a == ast_pkg::OFS_CONTROL
            || a == ast_pkg::OFS_STATUS || a == ast_pkg::OFS_TXDATA
            || a == ast_pkg::OFS_RXDATA || a == ast_pkg::OFS_BAUD;
    endfunction

    ast_pkg::ast_format_t   fmt;
    ast_pkg::ast_control_t  ctl;
    ast_pkg::ast_tx_state_t tx_state;
    ast_pkg::ast_rx_state_t rx_state;

    logic [15:0] baud;
    logic [15:0] div_cnt;
    logic [7:0]  tx_data_buf;
    logic [7:0]  rx_data_buf;
    logic        tx_buf_empty;
    logic        tx_end_flag;
    logic        rx_buf_full;
    logic        overrun_flag;
    logic        framing_flag;
    logic        parity_flag;
    logic        multiproc_bit;
    logic        mpb_rx;
    logic        sck_prev;
    logic        rxd_prev;
    logic [11:0] tx_shift_reg;
    logic [3:0]  tx_left;
    logic [3:0]  tx_ph;
    logic [9:0]  rx_shift_reg;
    logic [9:0]  rx_cur;
    logic [3:0]  rx_idx;
    logic [3:0]  rx_ph;
    logic        aw_hold;
    logic        w_hold;
    logic [ast_pkg::ADDR_W-1:0] aw_addr;
    logic [7:0]  w_byte;
    logic        w_lane;

    // Write channel: address and data may arrive in either order
    wire aw_go   = AXI_AWVALID_IN && AXI_AWREADY_OUT;
    wire w_go    = AXI_WVALID_IN && AXI_WREADY_OUT;
    wire wr_fire = (aw_hold || aw_go) && (w_hold || w_go);
    wire [ast_pkg::ADDR_W-1:0] wr_addr = aw_hold ? aw_addr : AXI_AWADDR_IN;
    wire [7:0] wr_byte = w_hold ? w_byte : AXI_WDATA_IN[7:0];
    wire       wr_lane = w_hold ? w_lane : AXI_WSTRB_IN[0];
    wire       wr_en   = wr_fire && wr_lane;
    wire wr_fmt  = wr_en && wr_addr == ast_pkg::OFS_FORMAT;
    wire wr_ctl  = wr_en && wr_addr == ast_pkg::OFS_CONTROL;
    wire wr_stat = wr_en && wr_addr == ast_pkg::OFS_STATUS;
    wire wr_tdat = wr_en && wr_addr == ast_pkg::OFS_TXDATA;
    wire wr_baud = wr_en && wr_addr == ast_pkg::OFS_BAUD;

    // Only one write is in flight: ready drops while the answer waits
    assign AXI_AWREADY_OUT = !aw_hold && !AXI_BVALID_OUT;
    assign AXI_WREADY_OUT  = !w_hold && !AXI_BVALID_OUT;
    assign AXI_ARREADY_OUT = !AXI_RVALID_OUT;

    // Read data selection
    wire ar_go = AXI_ARVALID_IN && AXI_ARREADY_OUT;
    wire [7:0] status_word = {tx_buf_empty, rx_buf_full, overrun_flag,
                              framing_flag, parity_flag, tx_end_flag,
                              mpb_rx, multiproc_bit};
    wire [15:0] rd_word =
        AXI_ARADDR_IN == ast_pkg::OFS_FORMAT  ? {8'h00, fmt}         :
        AXI_ARADDR_IN == ast_pkg::OFS_CONTROL ? {8'h00, ctl}         :
        AXI_ARADDR_IN == ast_pkg::OFS_STATUS  ? {8'h00, status_word} :
        AXI_ARADDR_IN == ast_pkg::OFS_TXDATA  ? {8'h00, tx_data_buf} :
        AXI_ARADDR_IN == ast_pkg::OFS_RXDATA  ? {8'h00, rx_data_buf} :
        AXI_ARADDR_IN == ast_pkg::OFS_BAUD    ? baud : 16'h0000;

    // Write side bus state
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            aw_hold        <= 1'b0;
            w_hold         <= 1'b0;
            aw_addr        <= '0;
            w_byte         <= 8'h00;
            w_lane         <= 1'b0;
            AXI_BVALID_OUT <= 1'b0;
            AXI_BRESP_OUT  <= ast_pkg::RESP_OK;
        end else begin
            if (aw_go) aw_addr <= AXI_AWADDR_IN;
            if (w_go) begin
                w_byte <= AXI_WDATA_IN[7:0];
                w_lane <= AXI_WSTRB_IN[0];
            end
            if (wr_fire) begin
                aw_hold        <= 1'b0;
                w_hold         <= 1'b0;
                AXI_BVALID_OUT <= 1'b1;
                AXI_BRESP_OUT  <= is_mapped(wr_addr) ? ast_pkg::RESP_OK
                                                     : ast_pkg::RESP_ERR;
            end else begin
                if (aw_go) aw_hold <= 1'b1;
                if (w_go) w_hold <= 1'b1;
                if (AXI_BREADY_IN) AXI_BVALID_OUT <= 1'b0;
            end
        end
    end

    // Read side bus state; reads have no side effects
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            AXI_RVALID_OUT <= 1'b0;
            AXI_RDATA_OUT  <= 32'h0000_0000;
            AXI_RRESP_OUT  <= ast_pkg::RESP_OK;
        end else if (ar_go) begin
            AXI_RVALID_OUT <= 1'b1;
            AXI_RDATA_OUT  <= {16'h0000, rd_word};
            AXI_RRESP_OUT  <= is_mapped(AXI_ARADDR_IN) ? ast_pkg::RESP_OK
                                                       : ast_pkg::RESP_ERR;
        end else if (AXI_RREADY_IN) begin
            AXI_RVALID_OUT <= 1'b0;
        end
    end

    // Upper baud byte travels with the held or live write data
    logic [7:0] w_hi;
    wire  [7:0] wr_hold_hi = w_hold ? w_hi : AXI_WDATA_IN[15:8];
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) w_hi <= 8'h00;
        else if (w_go) w_hi <= AXI_WDATA_IN[15:8];
    end

    // Software settings; software must idle both enables first R8
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            fmt         <= ast_pkg::FORMAT_RST;
            ctl         <= ast_pkg::CONTROL_RST;
            baud        <= ast_pkg::BAUD_RST;
            tx_data_buf <= 8'h00;
        end else begin
            if (wr_fmt) fmt <= wr_byte & ast_pkg::FORMAT_MASK;
            if (wr_ctl) ctl <= wr_byte & ast_pkg::CONTROL_MASK;
            if (wr_baud) baud <= AXI_WSTRB_IN[1] || w_hold ?
                                 {wr_hold_hi, wr_byte} : {baud[15:8], wr_byte};
            if (wr_tdat) tx_data_buf <= wr_byte;
        end
    end

    // Sixteen-times tick from the divider or the external pin
    wire ext_clk  = ctl.cks == ast_pkg::CKS_EXT; // R4
    wire tick_int = div_cnt >= baud;
    wire tick     = ext_clk ? (SERIAL_CLK_IN && !sck_prev) : tick_int; // R6
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            div_cnt  <= 16'h0000;
            sck_prev <= 1'b0;
        end else begin
            div_cnt  <= tick_int ? 16'h0000 : div_cnt + 16'h0001;
            sck_prev <= SERIAL_CLK_IN;
        end
    end

    // Pin drive only for the bit clock output; 00 and 11 leave it alone
    assign SERIAL_CLK_OE_OUT = !ext_clk && ctl.cks == ast_pkg::CKS_OUT; // R5

    // Transmit frame assembly
    wire       has_x  = fmt.pen || fmt.mp; // R3
    wire       x_bit  = fmt.mp ? multiproc_bit
                               : data_xor(tx_data_buf, fmt.char7) ^ fmt.podd; // R23
    wire [10:0] body8 = has_x ? {2'b11, x_bit, tx_data_buf}
                              : {3'b111, tx_data_buf};
    wire [10:0] body7 = has_x ? {3'b111, x_bit, tx_data_buf[6:0]}
                              : {4'b1111, tx_data_buf[6:0]};
    wire [11:0] tx_frame = {fmt.char7 ? body7 : body8, 1'b0}; // R1
    wire [3:0] tx_len = (fmt.char7 ? 4'd8 : 4'd9) + {3'b000, has_x}
                      + (fmt.stop2 ? 4'd2 : 4'd1);

    // Transmit events
    wire tx_bit_end = tx_state == ast_pkg::AST_TX_RUN && tick && tx_ph == ast_pkg::PH_LAST;
    wire tx_last    = tx_bit_end && tx_left == 4'd1;
    wire tx_load    = ctl.te && !tx_buf_empty
                      && (tx_state == ast_pkg::AST_TX_IDLE || tx_last); // R12 R13
    wire tx_end_ev  = ctl.te && tx_last && tx_buf_empty; // R14

    // Transmit shifter, line and bit-phase counter
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            tx_state     <= ast_pkg::AST_TX_IDLE;
            tx_shift_reg <= 12'hFFF;
            tx_left      <= 4'h0;
            tx_ph        <= 4'h0;
            TXD_OUT      <= 1'b1;
        end else begin
            if (tick) tx_ph <= tx_ph + 4'h1;
            if (!ctl.te) begin
                tx_state <= ast_pkg::AST_TX_IDLE;
                TXD_OUT  <= 1'b1;
            end else if (tx_load) begin
                tx_state     <= ast_pkg::AST_TX_RUN;
                tx_shift_reg <= tx_frame;
                tx_left      <= tx_len;
                tx_ph        <= 4'h0;
                TXD_OUT      <= tx_frame[0]; // R1
            end else if (tx_bit_end) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                tx_left      <= tx_left - 4'h1;
                TXD_OUT      <= tx_last ? 1'b1 : tx_shift_reg[1];
                if (tx_last) tx_state <= ast_pkg::AST_TX_IDLE; // R14
            end
        end
    end

    // Bit clock out; phase 8 of the bit rises mid-bit
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) SERIAL_CLK_OUT <= 1'b1;
        else SERIAL_CLK_OUT <= tx_ph[3]; // R7
    end

    // Receive geometry and checks
    wire [3:0] rx_dbits = fmt.char7 ? 4'd7 : 4'd8;
    wire [3:0] rx_need  = rx_dbits + {3'b000, has_x} + 4'd1;
    wire       err_any  = overrun_flag || framing_flag || parity_flag;
    wire       rx_fall  = rxd_prev && !RXD_IN;
    wire       rx_samp  = tick && rx_ph == ast_pkg::PH_SAMPLE;
    wire       rx_done  = rx_state == ast_pkg::AST_RX_BITS && rx_samp
                          && rx_idx == rx_need - 4'd1;
    wire [7:0] rx_word  = fmt.char7 ? {1'b0, rx_cur[6:0]} : rx_cur[7:0];
    wire       rx_xbit  = rx_cur[rx_dbits];
    wire       stop_bad = !rx_cur[rx_dbits + {3'b000, has_x}]; // R16
    wire       par_bad  = fmt.pen && !fmt.mp
                          && (data_xor(rx_word, fmt.char7) ^ rx_xbit ^ fmt.podd); // R16
    wire       ovr_ev   = rx_done && rx_buf_full; // R19
    wire       par_ev   = rx_done && par_bad; // R21
    wire       frm_ev   = rx_done && stop_bad; // R20
    wire       rx_store = rx_done && !rx_buf_full && !par_bad; // R20 R21
    wire       rx_ok    = rx_store && !stop_bad; // R17

    // Current sample merged into the collected bits
    always_comb begin
        rx_cur         = rx_shift_reg;
        rx_cur[rx_idx] = RXD_IN;
    end

    // Receive sequencer; holds off while an error flag stands
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            rx_state     <= ast_pkg::AST_RX_IDLE;
            rx_ph        <= 4'h0;
            rx_idx       <= 4'h0;
            rx_shift_reg <= 10'h3FF;
            rxd_prev     <= 1'b1;
        end else begin
            rxd_prev <= RXD_IN;
            if (rx_state != ast_pkg::AST_RX_IDLE && tick) rx_ph <= rx_ph + 4'h1;
            case (rx_state)
                ast_pkg::AST_RX_IDLE: begin
                    if (ctl.re && !err_any && rx_fall) begin // R2 R22
                        rx_state <= ast_pkg::AST_RX_START;
                        rx_ph    <= 4'h0;
                    end
                end
                ast_pkg::AST_RX_START: begin
                    if (rx_samp) begin
                        rx_idx   <= 4'h0;
                        rx_state <= RXD_IN ? ast_pkg::AST_RX_IDLE // Glitch, not a start
                                           : ast_pkg::AST_RX_BITS;
                    end
                end
                ast_pkg::AST_RX_BITS: begin
                    if (rx_samp) begin
                        rx_shift_reg <= rx_cur; // R15
                        rx_idx       <= rx_idx + 4'h1;
                        if (rx_done) rx_state <= ast_pkg::AST_RX_IDLE;
                    end
                end
                default: rx_state <= ast_pkg::AST_RX_IDLE;
            endcase
            if (!ctl.re) rx_state <= ast_pkg::AST_RX_IDLE;
        end
    end

    // Status flags: a hardware set beats a software clear in the same cycle
    wire clr_tx_buf_empty = wr_stat && !wr_byte[ast_pkg::ST_TX_BUF_EMPTY];
    wire clr_tx_end_flag = wr_stat && !wr_byte[ast_pkg::ST_TX_END_FLAG];
    wire clr_rx_buf_full = wr_stat && !wr_byte[ast_pkg::ST_RX_BUF_FULL];
    wire clr_ovr  = wr_stat && !wr_byte[ast_pkg::ST_OVR];
    wire clr_frm  = wr_stat && !wr_byte[ast_pkg::ST_FRM];
    wire clr_par  = wr_stat && !wr_byte[ast_pkg::ST_PAR];
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN) begin
            tx_buf_empty  <= 1'b1;
            tx_end_flag   <= 1'b1;
            rx_buf_full   <= 1'b0;
            overrun_flag  <= 1'b0;
            framing_flag  <= 1'b0;
            parity_flag   <= 1'b0;
            multiproc_bit <= 1'b0;
            mpb_rx        <= 1'b0;
            rx_data_buf   <= 8'h00;
        end else begin
            tx_buf_empty <= !ctl.te || tx_load || (tx_buf_empty && !clr_tx_buf_empty); // R9 R12
            tx_end_flag  <= tx_end_ev || (tx_end_flag && !clr_tx_end_flag && !tx_load); // R14
            rx_buf_full  <= rx_ok || (rx_buf_full && !clr_rx_buf_full); // R17 R18
            overrun_flag <= ovr_ev || (overrun_flag && !clr_ovr); // R19
            framing_flag <= frm_ev || (framing_flag && !clr_frm); // R20
            parity_flag  <= par_ev || (parity_flag && !clr_par); // R21
            if (wr_stat) multiproc_bit <= wr_byte[ast_pkg::ST_MPB_TX];
            if (rx_store) begin
                rx_data_buf <= rx_word; // R10
                mpb_rx      <= fmt.mp && rx_xbit;
            end
        end
    end

    // Request levels; the surrounding controller owns priority
    assign TX_EMPTY_IRQ_OUT = ctl.tx_irq_enable && tx_buf_empty && ctl.te; // R12
    assign TX_END_IRQ_OUT   = ctl.tx_end_irq_enable && tx_end_flag; // R14
    assign RX_FULL_IRQ_OUT  = ctl.rx_irq_enable && rx_buf_full; // R17
    assign RX_ERROR_IRQ_OUT = ctl.rx_irq_enable && err_any; // R18

    // Checks
    property p_te_off;
        !ctl.te |=> tx_buf_empty && TXD_OUT;
    endproperty
    a_te_off: assert property (p_te_off) else $error("TE off must empty buffer"); // R9

    property p_re_keep;
        !ctl.re && rx_state == ast_pkg::AST_RX_IDLE |=> $stable(rx_data_buf);
    endproperty
    a_re_keep: assert property (p_re_keep) else $error("RX buffer moved with RE off"); // R10

    property p_load;
        tx_state == ast_pkg::AST_TX_IDLE && ctl.te && !tx_buf_empty
        |=> tx_buf_empty && !TXD_OUT && tx_state == ast_pkg::AST_TX_RUN;
    endproperty
    a_load: assert property (p_load) else $error("Load did not start a frame"); // R12

    property p_idle_mark;
        tx_state == ast_pkg::AST_TX_IDLE |-> TXD_OUT;
    endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("Idle line not high"); // R1

    property p_tx_end_flag;
        tx_end_ev |=> tx_end_flag && tx_state == ast_pkg::AST_TX_IDLE;
    endproperty
    a_tx_end_flag: assert property (p_tx_end_flag) else $error("TX end not flagged"); // R14

    property p_start;
        rx_state == ast_pkg::AST_RX_START && rx_samp && !RXD_IN
        |=> rx_state == ast_pkg::AST_RX_BITS && rx_ph == 4'h8;
    endproperty
    a_start: assert property (p_start) else $error("Start bit not taken mid-bit"); // R2

    property p_overrun;
        ovr_ev |=> overrun_flag && $stable(rx_data_buf) && rx_buf_full;
    endproperty
    a_overrun: assert property (p_overrun) else $error("Overrun mishandled"); // R19

    property p_parity;
        rx_done && par_bad && !rx_buf_full |=> parity_flag && $stable(rx_data_buf);
    endproperty
    a_parity: assert property (p_parity) else $error("Parity error mishandled"); // R21

    property p_framing;
        rx_done && stop_bad && !par_bad && !rx_buf_full
        |=> framing_flag && !rx_buf_full && rx_data_buf == $past(rx_word);
    endproperty
    a_framing: assert property (p_framing) else $error("Framing error mishandled"); // R20

    property p_good;
        rx_ok |=> rx_buf_full && rx_data_buf == $past(rx_word) && !RX_ERROR_IRQ_OUT;
    endproperty
    a_good: assert property (p_good) else $error("Good character not stored"); // R17

    property p_suspend;
        err_any && rx_state == ast_pkg::AST_RX_IDLE |=> rx_state == ast_pkg::AST_RX_IDLE;
    endproperty
    a_suspend: assert property (p_suspend) else $error("Receive ran with error set"); // R22

    property p_clk_pin;
        ctl.cks != ast_pkg::CKS_OUT |-> !SERIAL_CLK_OE_OUT;
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("Clock pin driven wrongly"); // R5

endmodule

`default_nettype wire

// ==== testbench/ast_peer.sv ====
// Serial peer model: drives frames onto the receive line, captures frames from the transmit line.
// One bit lasts bt system clocks: 16 for divisor 0, 32 for the external source.
`default_nettype none
module ast_peer (
    input  wire logic       clk,
    input  wire logic       txd,
    output logic            rxd,
    output logic [7:0]      got
);
    timeunit 1ns;
    timeprecision 1ps;
    int bt = 16; // System clocks per bit
    initial rxd = 1'b1; // Mark level between frames
    // Capture at bit centres, LSB first; samples stay clear of the bit edges
    always begin
        @(negedge txd);
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bt) @(posedge clk);
            got[i] = txd;
        end
    end
    // Start low, data LSB first, then the given stop level, then idle
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (bt) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (2 * bt) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== testbench/ast_serial_unit_tb_top.sv ====
// Testbench for the serial unit: registers over AXI4-Lite, peer model on the serial pins.
// Assumes divisor 0 is written first, so one bit lasts 16 clocks.
`default_nettype none
module ast_serial_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rdata, v;
    logic [1:0] bresp, rresp, resp;
    logic awr, wrd, bv, arr, rv, txd, rxd, sclk, soe, i0, i1, i2, i3;
    logic [7:0] got;
    int n_mismatch = 0, compares = 0, cyc = 0;
    logic [8:0] rows [4] = '{9'h1A5, 9'h13C, 9'h05A, 9'h0C3}; // [8] transmit, [7:0] byte
    always #2.5 clk = ~clk;
    logic sck = 1'b0;
    always @(posedge clk) sck <= ~sck; // free-running source, kept up through setup
    ast_serial_unit u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AXI_AWADDR_IN(awa),
        .AXI_AWVALID_IN(awv), .AXI_AWREADY_OUT(awr), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(4'hF),
        .AXI_WVALID_IN(wv), .AXI_WREADY_OUT(wrd), .AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bv),
        .AXI_BREADY_IN(bre), .AXI_ARADDR_IN(ara), .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(arr),
        .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rre),
        .TXD_OUT(txd), .RXD_IN(rxd), .SERIAL_CLK_IN(sck), .SERIAL_CLK_OUT(sclk),
        .SERIAL_CLK_OE_OUT(soe), .TX_EMPTY_IRQ_OUT(i0), .TX_END_IRQ_OUT(i1),
        .RX_FULL_IRQ_OUT(i2), .RX_ERROR_IRQ_OUT(i3));
    ast_peer peer (.clk(clk), .txd(txd), .rxd(rxd), .got(got));
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    // Ready and valid are looked at mid-cycle, so the edge updates have landed
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
        do begin
            @(negedge clk);
            ta = awr; tw = wrd; tb = bv; resp = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!tb);
    endtask
    task automatic rd(input logic [4:0] a);
        logic ta, tb;
        ara <= a; arv <= 1'b1; rre <= 1'b1;
        do begin
            @(negedge clk);
            ta = arr; tb = rv; v = rdata; resp = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end while (!tb);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Load a byte and clear the empty flag, keeping the other flags
    task automatic txb(input logic [7:0] b);
        wr(5'h0C, {24'h0, b}); wr(5'h08, 32'h7E);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(5'h08); chk("status reset", v, 32'h84);
        wr(5'h14, 32'h0); wr(5'h00, 32'h0); wr(5'h04, 32'hF4);
        // Ordinary rows: transmit rows compare the peer's capture, receive rows the buffer
        foreach (rows[i]) begin
            if (rows[i][8]) begin
                txb(rows[i][7:0]);
                do rd(5'h08); while (!v[2]);
                chk("tx byte", got, rows[i][7:0]);
                chk("tx irqs", {i0, i1}, 2'b11);
            end else begin
                peer.send(rows[i][7:0], 1'b1);
                rd(5'h10); chk("rx byte", v, rows[i][7:0]);
                chk("rx irq", i2, 1);
                wr(5'h08, 32'hBE);
            end
            $display("row %0d done", i);
        end
        txb(8'h81); txb(8'h18); // Second byte queued while the first is on the line
        do rd(5'h08); while (!v[2]);
        chk("back to back", got, 8'h18);
        peer.send(8'h66, 1'b0); rd(5'h08); chk("framing status", v, 32'h94);
        chk("error irq", i3, 1);
        peer.send(8'h11, 1'b1); rd(5'h10); chk("framing data", v, 32'h66);
        wr(5'h08, 32'hEE); peer.send(8'h21, 1'b1); peer.send(8'h42, 1'b1);
        wr(5'h04, 32'h60); rd(5'h08); chk("overrun status", v, 32'hE4);
        rd(5'h10); chk("overrun data", v, 32'h21);
        wr(5'h04, 32'h00); wr(5'h08, 32'h1C); rd(5'h08); chk("te off", v[7], 1);
        rd(5'h1C); chk("unmapped", {resp, v[29:0]}, 32'h80000000);
        // External 16x source, seven data bits with even parity: a bit is 32 clocks
        wr(5'h00, 32'h18); wr(5'h04, 32'h72); chk("pin idle", soe, 0);
        peer.bt = 32; txb(8'h07); do rd(5'h08); while (!v[2]);
        chk("parity tx", got, 8'h87);
        peer.send(8'h87, 1'b1); rd(5'h10); chk("parity rx", v, 32'h07);
        wr(5'h08, 32'hBE); peer.send(8'h86, 1'b1);
        rd(5'h08); chk("parity status", v, 32'h8C);
        rd(5'h10); chk("parity data", v, 32'h07);
        wr(5'h04, 32'h00); wr(5'h04, 32'h01); chk("pin drive", soe, 1);
        $display("awkward cases done");
        results();
    end
endmodule
`default_nettype wire
